// ==== mfb_port_fifo.sv ====
`timescale 1ns/1ps
package mfb_pkg;
    localparam int NUM_PORTS = 8;
    localparam int PORT_W = 3;
    localparam int DATA_W = 64;
    localparam int HALF_W = 32;
    localparam int BE_W = 8;
    localparam int HALF_BE_W = 4;
    localparam int FIFO_DEPTH = 32;
    typedef enum logic [1:0] {
        MODE_FULL = 2'h0,
        MODE_NARROW = 2'h1,
        MODE_SPLIT = 2'h2
    } mfb_mode_e;
    typedef struct packed {
        logic isStat;
        logic sop;
        logic eop;
        logic [BE_W-1:0] beN;
        logic [DATA_W-1:0] data;
    } mfb_entry_s;
    localparam int ENTRY_W = $bits(mfb_entry_s);
endpackage : mfb_pkg

module mfb_port_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic push,
    input wire logic [W-1:0] wdata,
    // Drain side
    input wire logic pop,
    output logic [W-1:0] rdata,
    output logic empty,
    output logic full,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } mfb_fifo_s;
    mfb_fifo_s st_r;
    mfb_fifo_s st_nxt;
    logic [W-1:0] mem [DEPTH];
    logic doPush;
    logic doPop;

    // Full pushes are dropped; nothing upstream can stall
    assign doPush = push && (st_r.cnt != (AW+1)'(DEPTH));
    assign doPop = pop && (st_r.cnt != '0);
    assign rdata = mem[st_r.rp];
    assign empty = (st_r.cnt == '0);
    assign full = (st_r.cnt == (AW+1)'(DEPTH));
    assign count = st_r.cnt;

    always_comb
    begin
        st_nxt = st_r;
        if (doPush)
        begin
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (doPop)
        begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(doPush) - (AW+1)'(doPop);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Storage has no reset; reset flushes by clearing pointers
    always_ff @(posedge clk)
    begin
        if (doPush)
        begin
            mem[st_r.wp] <= wdata;
        end
    end
endmodule : mfb_port_fifo

// ==== mfb_data_path.sv ====
`timescale 1ns/1ps
module mfb_data_path #(
    parameter int DEPTH = mfb_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Static bus configuration
    input wire logic [1:0] busMode,
    // Bus selects
    input wire logic txSel_n,
    input wire logic rxSel_n,
    input wire logic [mfb_pkg::PORT_W-1:0] portSel,
    input wire logic [mfb_pkg::PORT_W-1:0] txPortSel,
    input wire logic rxKeep,
    // Data lanes
    input wire logic [mfb_pkg::DATA_W-1:0] dataIn,
    output logic [mfb_pkg::DATA_W-1:0] dataOut,
    output logic dataOeLo,
    output logic dataOeHi,
    // Byte enables
    input wire logic [mfb_pkg::BE_W-1:0] beIn_n,
    output logic [mfb_pkg::BE_W-1:0] beOut_n,
    output logic beOeLo,
    output logic beOeHi,
    // Packet markers
    input wire logic sopIn,
    input wire logic eopIn,
    output logic sopOut,
    output logic eopOut,
    output logic markOe,
    output logic rxWordValid,
    // MAC receive fill side
    input wire logic macRxValid,
    input wire logic [mfb_pkg::PORT_W-1:0] macRxPort,
    input wire logic [mfb_pkg::ENTRY_W-1:0] macRxEntry,
    // MAC transmit drain side
    input wire logic macTxPop,
    input wire logic [mfb_pkg::PORT_W-1:0] macTxPort,
    output logic [mfb_pkg::ENTRY_W-1:0] macTxEntry,
    output logic macTxValid
);
    localparam int CW = $clog2(DEPTH) + 1;
    localparam int NP = mfb_pkg::NUM_PORTS;
    localparam int HW = mfb_pkg::HALF_W;
    localparam int HB = mfb_pkg::HALF_BE_W;

    typedef struct packed {
        logic [mfb_pkg::DATA_W-1:0] dout;
        logic [mfb_pkg::BE_W-1:0] beN;
        logic sop;
        logic eop;
        logic oeLo;
        logic oeHi;
        logic rxValid;
        logic [mfb_pkg::ENTRY_W-1:0] txEntry;
        logic txValid;
    } mfb_state_s;

    mfb_state_s st_r;
    mfb_state_s st_nxt;
    mfb_pkg::mfb_mode_e mode;
    mfb_pkg::mfb_entry_s txW;
    mfb_pkg::mfb_entry_s selHead;
    mfb_pkg::mfb_entry_s rxHead [NP];
    logic [mfb_pkg::ENTRY_W-1:0] rxHeadRaw [NP];
    logic [mfb_pkg::ENTRY_W-1:0] txHeadRaw [NP];
    logic [CW-1:0] rxCnt [NP];
    logic [NP-1:0] txPush;
    logic [NP-1:0] txPop;
    logic [NP-1:0] rxPush;
    logic [NP-1:0] rxPop;
    logic [NP-1:0] rxEmpty;
    logic [NP-1:0] txEmpty;
    logic [mfb_pkg::PORT_W-1:0] wrPort;
    logic selValid;
    logic [CW-1:0] selCnt;

    assign mode = mfb_pkg::mfb_mode_e'(busMode);

    // Transmit word assembly per bus mode
    always_comb
    begin
        txW = '0;
        wrPort = portSel;
        unique case (mode)
            mfb_pkg::MODE_FULL:
            begin
                txW.data = dataIn;
                txW.beN = beIn_n;
                txW.sop = sopIn;
                txW.eop = eopIn;
            end
            mfb_pkg::MODE_NARROW:
            begin
                // Upper enables are held invalid whatever the board does
                txW.data[HW-1:0] = dataIn[HW-1:0];
                txW.beN = {{HB{1'b1}}, beIn_n[HB-1:0]};
                txW.sop = sopIn;
                txW.eop = eopIn;
            end
            mfb_pkg::MODE_SPLIT:
            begin
                // Transmit uses the upper lanes; port comes from its own select
                txW.data[HW-1:0] = dataIn[mfb_pkg::DATA_W-1:HW];
                txW.beN = {{HB{1'b1}}, beIn_n[mfb_pkg::BE_W-1:HB]};
                wrPort = txPortSel;
            end
            default:
            begin
                txW.beN = '1;
            end
        endcase
    end

    // Split mode receive is never muddled by transmit-side marker pins
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++)
        begin : g_port
            localparam logic [mfb_pkg::PORT_W-1:0] PID = mfb_pkg::PORT_W'(gi);
            assign txPush[gi] = !txSel_n && (wrPort == PID);
            assign txPop[gi] = macTxPop && (macTxPort == PID);
            assign rxPush[gi] = macRxValid && (macRxPort == PID);
            assign rxPop[gi] = !rxSel_n && !rxKeep && (portSel == PID);
            assign rxHead[gi] = mfb_pkg::mfb_entry_s'(rxHeadRaw[gi]);
            mfb_port_fifo #(
                .W(mfb_pkg::ENTRY_W),
                .DEPTH(DEPTH)
            ) u_tx (
                .clk(clk),
                .rst_n(rst_n),
                .push(txPush[gi]),
                .wdata(mfb_pkg::ENTRY_W'(txW)),
                .pop(txPop[gi]),
                .rdata(txHeadRaw[gi]),
                .empty(txEmpty[gi]),
                .full(),
                .count()
            );
            mfb_port_fifo #(
                .W(mfb_pkg::ENTRY_W),
                .DEPTH(DEPTH)
            ) u_rx (
                .clk(clk),
                .rst_n(rst_n),
                .push(rxPush[gi]),
                .wdata(macRxEntry),
                .pop(rxPop[gi]),
                .rdata(rxHeadRaw[gi]),
                .empty(rxEmpty[gi]),
                .full(),
                .count(rxCnt[gi])
            );
        end
    endgenerate

    assign selHead = rxHead[portSel];
    assign selValid = !rxEmpty[portSel];
    assign selCnt = rxCnt[portSel];

    // Receive read path and transmit drain view
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.oeLo = !rxSel_n;
        st_nxt.oeHi = !rxSel_n && (mode == mfb_pkg::MODE_FULL);
        st_nxt.rxValid = !rxSel_n && selValid;
        st_nxt.dout = '0;
        st_nxt.beN = '1;
        st_nxt.sop = 1'b0;
        st_nxt.eop = 1'b0;
        if (!rxSel_n && selValid)
        begin
            st_nxt.beN = selHead.beN;
            if (mode == mfb_pkg::MODE_FULL)
            begin
                st_nxt.dout = selHead.data;
            end
            else
            begin
                st_nxt.dout[HW-1:0] = selHead.data[HW-1:0];
                st_nxt.beN[mfb_pkg::BE_W-1:HB] = '1;
            end
            // Status word carries no markers; its data replaces packet data
            st_nxt.sop = selHead.sop && !selHead.isStat;
            st_nxt.eop = selHead.eop && !selHead.isStat;
        end
        st_nxt.txEntry = txHeadRaw[macTxPort];
        st_nxt.txValid = !txEmpty[macTxPort];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.beN <= '1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign dataOut = st_r.dout;
    assign dataOeLo = st_r.oeLo;
    assign dataOeHi = st_r.oeHi;
    assign beOut_n = st_r.beN;
    assign beOeLo = st_r.oeLo;
    assign beOeHi = st_r.oeHi;
    assign sopOut = st_r.sop;
    assign eopOut = st_r.eop;
    assign markOe = st_r.oeLo;
    assign rxWordValid = st_r.rxValid;
    assign macTxEntry = st_r.txEntry;
    assign macTxValid = st_r.txValid;

    default clocking cbSys @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_sel_drives;
        !rxSel_n |=> dataOeLo && beOeLo && markOe;
    endproperty
    a_sel_drives: assert property (p_sel_drives)
        else $error("receive select did not enable drivers");

    property p_no_sel_quiet;
        rxSel_n |=> !dataOeLo && !dataOeHi && !markOe && !sopOut;
    endproperty
    a_no_sel_quiet: assert property (p_no_sel_quiet)
        else $error("receive outputs driven without select");

    property p_split_low_only;
        (mode == mfb_pkg::MODE_SPLIT) |=> !dataOeHi && !beOeHi
            && (dataOut[mfb_pkg::DATA_W-1:HW] == '0);
    endproperty
    a_split_low_only: assert property (p_split_low_only)
        else $error("split mode drove upper lanes");

    property p_full_data;
        (!rxSel_n && selValid && mode == mfb_pkg::MODE_FULL)
            |=> dataOeHi && (dataOut == $past(selHead.data));
    endproperty
    a_full_data: assert property (p_full_data)
        else $error("full mode read data mismatch");

    property p_be_follow;
        (!rxSel_n && selValid)
            |=> beOut_n[HB-1:0] == $past(selHead.beN[HB-1:0]);
    endproperty
    a_be_follow: assert property (p_be_follow)
        else $error("receive byte enables wrong");

    property p_empty_none;
        (!rxSel_n && !selValid) |=> (beOut_n == '1) && !rxWordValid;
    endproperty
    a_empty_none: assert property (p_empty_none)
        else $error("empty read showed valid lanes");

    property p_keep;
        (!rxSel_n && rxKeep && !macRxValid)
            |=> rxCnt[$past(portSel)] == $past(selCnt);
    endproperty
    a_keep: assert property (p_keep)
        else $error("receive-keep lost a word");

    property p_marks;
        (!rxSel_n && selValid && !selHead.isStat)
            |=> (sopOut == $past(selHead.sop))
            && (eopOut == $past(selHead.eop));
    endproperty
    a_marks: assert property (p_marks)
        else $error("packet markers wrong");

    property p_status;
        (!rxSel_n && selValid && selHead.isStat)
            |=> !sopOut && !eopOut && rxWordValid;
    endproperty
    a_status: assert property (p_status)
        else $error("status word carried markers");

    c_full_read: cover property (
        !rxSel_n && selValid && mode == mfb_pkg::MODE_FULL);
    c_keep: cover property (!rxSel_n && rxKeep && selValid);
    c_status: cover property (!rxSel_n && selValid && selHead.isStat);
    c_split_tx: cover property (!txSel_n && mode == mfb_pkg::MODE_SPLIT);
endmodule : mfb_data_path

// ==== mfb_bus_master.sv ====
`timescale 1ns/1ps
module mfb_bus_master (
    // Clock
    input wire logic clk,
    // Selects
    output logic txSel_n,
    output logic rxSel_n,
    output logic [2:0] portSel,
    output logic [2:0] txPortSel,
    output logic rxKeep,
    // Write lanes and markers
    output logic [63:0] dataIn,
    output logic [7:0] beIn_n,
    output logic sopIn,
    output logic eopIn
);
    initial
    begin
        txSel_n = 1'h1;
        rxSel_n = 1'h1;
        portSel = 3'h0;
        txPortSel = 3'h0;
        rxKeep = 1'h0;
        dataIn = 64'h0;
        beIn_n = 8'hFF;
        sopIn = 1'h0;
        eopIn = 1'h0;
    end

    // One transmit word; split mode scrambles portSel to prove txPortSel
    task automatic wrWord(input logic [2:0] port, input logic split,
        input logic [63:0] d, input logic [7:0] be, input logic sop,
        input logic eop);
        @(posedge clk);
        txSel_n <= 1'h0;
        portSel <= split ? ~port : port;
        txPortSel <= port;
        dataIn <= d;
        beIn_n <= be;
        sopIn <= sop;
        eopIn <= eop;
        @(posedge clk);
        txSel_n <= 1'h1;
        // Released lanes must not keep showing the last word
        dataIn <= ~d;
        beIn_n <= ~be;
        sopIn <= 1'h0;
        eopIn <= 1'h0;
    endtask : wrWord

    task automatic rdWord(input logic [2:0] port, input logic keep);
        @(posedge clk);
        rxSel_n <= 1'h0;
        portSel <= port;
        rxKeep <= keep;
        @(posedge clk);
        rxSel_n <= 1'h1;
        rxKeep <= 1'h0;
    endtask : rdWord
endmodule : mfb_bus_master

// ==== multiport_fifo_bus_data_path_tb.sv ====
`timescale 1ns/1ps
module multiport_fifo_bus_data_path_tb;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [1:0] busMode = 2'h0;
    logic macRxValid = 1'h0;
    logic [2:0] macRxPort = 3'h0;
    logic [74:0] macRxEntry = 75'h0;
    logic macTxPop = 1'h0;
    logic [2:0] macTxPort = 3'h0;
    logic txSel_n, rxSel_n, rxKeep, sopIn, eopIn;
    logic [2:0] portSel, txPortSel;
    logic [63:0] dataIn, dataOut;
    logic [7:0] beIn_n, beOut_n;
    logic dataOeLo, dataOeHi, beOeLo, beOeHi, sopOut, eopOut, markOe;
    logic rxWordValid, macTxValid;
    logic [74:0] macTxEntry;
    mfb_pkg::mfb_entry_s txView;
    int errTotal = 0;
    int checksDone = 0;

    assign txView = macTxEntry;

    initial
    begin
        forever #4 clk = ~clk;
    end

    mfb_bus_master m (.clk(clk), .txSel_n(txSel_n), .rxSel_n(rxSel_n),
        .portSel(portSel), .txPortSel(txPortSel), .rxKeep(rxKeep),
        .dataIn(dataIn), .beIn_n(beIn_n), .sopIn(sopIn), .eopIn(eopIn));

    // Small depth keeps runs short
    mfb_data_path #(.DEPTH(4)) dut (.clk(clk), .rst_n(rst_n),
        .busMode(busMode), .txSel_n(txSel_n), .rxSel_n(rxSel_n),
        .portSel(portSel), .txPortSel(txPortSel), .rxKeep(rxKeep),
        .dataIn(dataIn), .dataOut(dataOut), .dataOeLo(dataOeLo),
        .dataOeHi(dataOeHi), .beIn_n(beIn_n), .beOut_n(beOut_n),
        .beOeLo(beOeLo), .beOeHi(beOeHi), .sopIn(sopIn), .eopIn(eopIn),
        .sopOut(sopOut), .eopOut(eopOut), .markOe(markOe),
        .rxWordValid(rxWordValid), .macRxValid(macRxValid),
        .macRxPort(macRxPort), .macRxEntry(macRxEntry),
        .macTxPop(macTxPop), .macTxPort(macTxPort),
        .macTxEntry(macTxEntry), .macTxValid(macTxValid));

    task automatic chk(input string what, input logic [74:0] seen,
        input logic [74:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic summarize;
        $display("Checks %0d errors %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    task automatic push(input logic [2:0] port, input logic [74:0] e);
        @(posedge clk);
        macRxValid <= 1'h1;
        macRxPort <= port;
        macRxEntry <= e;
        @(posedge clk);
        macRxValid <= 1'h0;
    endtask : push

    task automatic setMode(input logic [1:0] mode, input logic [2:0] txp);
        @(posedge clk);
        busMode <= mode;
        macTxPort <= txp;
    endtask : setMode

    // Judges the word returned by the read that just completed
    task automatic rxCheck(input logic wide, input mfb_pkg::mfb_entry_s e);
        logic [63:0] d;
        d = wide ? e.data : {32'h0, e.data[31:0]};
        #1;
        chk("rx data", dataOut, d);
        chk("rx be", beOut_n[3:0], e.beN[3:0]);
        if (wide)
            chk("rx be hi", beOut_n, e.beN);
        chk("rx sop", sopOut, e.sop & ~e.isStat);
        chk("rx eop", eopOut, e.eop & ~e.isStat);
        chk("rx oe", {dataOeLo, dataOeHi, beOeLo, beOeHi, markOe,
            rxWordValid}, {1'h1, wide, 1'h1, wide, 2'h3});
    endtask : rxCheck

    task automatic txFullScn;
        setMode(mfb_pkg::MODE_FULL, 3'h5);
        m.wrWord(3'h5, 1'h0, 64'h1122334455667788, 8'hF0, 1'h1, 1'h0);
        m.wrWord(3'h5, 1'h0, 64'h99AABBCCDDEEFF00, 8'h00, 1'h0, 1'h1);
        @(posedge clk);
        #1;
        chk("tx first", macTxEntry,
            {3'h2, 8'hF0, 64'h1122334455667788});
        chk("tx valid", macTxValid, 1'h1);
        @(posedge clk);
        macTxPop <= 1'h1;
        @(posedge clk);
        macTxPop <= 1'h0;
        @(posedge clk);
        #1;
        chk("tx last", macTxEntry,
            {3'h1, 8'h00, 64'h99AABBCCDDEEFF00});
        @(posedge clk);
        macTxPop <= 1'h1;
        @(posedge clk);
        macTxPop <= 1'h0;
        @(posedge clk);
        #1;
        chk("tx drained", macTxValid, 1'h0);
    endtask : txFullScn

    task automatic rxFullScn;
        logic [74:0] e1, e2, st;
        e1 = {3'h2, 8'h00, 64'hA5A5A5A5_5A5A5A5A};
        e2 = {3'h1, 8'hFC, 64'h0000BEEF_0F0F0F0F};
        st = {3'h4, 8'h00, 64'h00000000_00C0FFEE};
        setMode(mfb_pkg::MODE_FULL, 3'h0);
        push(3'h4, {3'h3, 8'h0F, 64'hDEADDEADDEADDEAD});
        push(3'h3, e1);
        push(3'h3, e2);
        push(3'h3, st);
        m.rdWord(3'h3, 1'h1);
        rxCheck(1'h1, e1);
        m.rdWord(3'h3, 1'h0);
        rxCheck(1'h1, e1);
        m.rdWord(3'h3, 1'h0);
        rxCheck(1'h1, e2);
        m.rdWord(3'h3, 1'h0);
        rxCheck(1'h1, st);
        m.rdWord(3'h3, 1'h0);
        #1;
        chk("empty valid", rxWordValid, 1'h0);
        chk("empty be", beOut_n, 8'hFF);
        @(posedge clk);
        #1;
        chk("oe idle", {dataOeLo, beOeLo, markOe}, 3'h0);
    endtask : rxFullScn

    task automatic splitScn;
        logic [74:0] e;
        e = {3'h3, 8'hF3, 64'h0123456789ABCDEF};
        setMode(mfb_pkg::MODE_SPLIT, 3'h2);
        m.wrWord(3'h2, 1'h1, 64'hCAFEF00D_77777777, 8'h0F, 1'h1, 1'h1);
        @(posedge clk);
        #1;
        chk("split tx data", txView.data[31:0], 32'hCAFEF00D);
        chk("split tx be", txView.beN, 8'hF0);
        chk("split tx mark", {txView.sop, txView.eop}, 2'h0);
        push(3'h6, e);
        m.rdWord(3'h6, 1'h0);
        rxCheck(1'h0, e);
    endtask : splitScn

    task automatic narrowScn;
        logic [74:0] e;
        e = {3'h2, 8'hF8, 64'hFEDCBA98_13579BDF};
        setMode(mfb_pkg::MODE_NARROW, 3'h1);
        m.wrWord(3'h1, 1'h0, 64'h0BADC0DE_2468ACE0, 8'hF8, 1'h1, 1'h0);
        @(posedge clk);
        #1;
        chk("narrow tx data", txView.data[31:0], 32'h2468ACE0);
        chk("narrow tx be", txView.beN, 8'hF8);
        chk("narrow tx mark", {txView.sop, txView.eop}, 2'h2);
        push(3'h1, e);
        m.rdWord(3'h1, 1'h0);
        rxCheck(1'h0, e);
    endtask : narrowScn

    // Reset in mid-run must flush the port 0 receive FIFO and drop dataOeLo and macTxValid
    task automatic resetScn;
        push(3'h0, {3'h2, 8'h00, 64'h0000000000000055});
        @(posedge clk);
        rst_n <= 1'h0;
        @(posedge clk);
        #1;
        chk("reset quiet", {dataOeLo, macTxValid}, 2'h0);
        @(posedge clk);
        rst_n <= 1'h1;
        m.rdWord(3'h0, 1'h0);
        #1;
        chk("flush valid", rxWordValid, 1'h0);
        chk("flush be", beOut_n, 8'hFF);
    endtask : resetScn

    initial
    begin
        repeat (3000) @(posedge clk);
        errTotal++;
        summarize();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        #1;
        chk("reset be", beOut_n, 8'hFF);
        @(posedge clk);
        rst_n <= 1'h1;
        txFullScn();
        rxFullScn();
        splitScn();
        narrowScn();
        resetScn();
        summarize();
    end
endmodule : multiport_fifo_bus_data_path_tb
